/* File: sim/power_reset_bod_control_properties.sv */
// Port-level assertions for the power and reset slice
`timescale 1ns/1ps
module power_reset_bod_control_properties
  import sysctl_pkg::*;
#(
  parameter logic [31:0] PART_ID = PART_ID_DEFAULT
) (
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire sysctl_pkg::bus_req_t bus_req,
  input wire logic [31:0]          rdata,
  input wire logic                 ext_reset_n,
  input wire logic                 watchdog_reset,
  input wire logic                 power_on_detect,
  input wire logic                 software_reset_req,
  input wire logic [2:0]           supply_below,
  input wire logic                 fro_running,
  input wire logic                 watchdog_lock,
  input wire logic                 deep_sleep,
  input wire logic                 chip_reset_n,
  input wire logic                 fro_clock_enable,
  input wire logic [15:0]          power_off,
  input wire logic                 brownout_irq,
  input wire logic                 wake_request,
  input wire logic [31:0]          boot_vector_addr
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire mapped = (bus_req.addr == RUN_POWER_GATING_ADDR) || (bus_req.addr == PART_IDENTIFICATION_ADDR) ||
                (bus_req.addr == BROWNOUT_CTRL_ADDR) || (bus_req.addr == RESET_STATUS_ADDR);
  // Sources idle, oscillator up
  wire quiet = ext_reset_n && fro_running && !power_on_detect && !software_reset_req && !watchdog_reset &&
               (supply_below == 3'h0);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_idle: assert property ((!$past(bus_req.rd) || !$past(reset_n)) |-> rdata == 32'h0)
    else $error("rdata not idle");
  a_id_read: assert property (
    ($past(bus_req.rd) && $past(reset_n) && $past(bus_req.addr) == PART_IDENTIFICATION_ADDR) |-> rdata == PART_ID)
    else $error("part id");
  a_unmapped_zero: assert property (($past(bus_req.rd) && $past(reset_n) && !$past(mapped)) |-> rdata == 32'h0)
    else $error("unmapped read");
  a_gating_reserved: assert property (
    ($past(bus_req.rd) && $past(reset_n) && $past(bus_req.addr) == RUN_POWER_GATING_ADDR)
    |-> ((rdata & 32'hffff_5f80) == 32'h0) && rdata[5]) else $error("gating reserved bits");
  a_source_reset: assert property ((software_reset_req || watchdog_reset) |=> !chip_reset_n)
    else $error("source ignored");
  a_release_gate: assert property (
    $rose(chip_reset_n) |-> $past(ext_reset_n, 3) && $past(fro_running, 3) && !$past(software_reset_req))
    else $error("early release");
  a_release_bound: assert property (quiet [*8] |-> ##[0:4] chip_reset_n)
    else $error("no release");
  a_reset_values: assert property (
    $rose(chip_reset_n) |-> (power_off & 16'hffbf) == 16'ha030 && boot_vector_addr == BOOT_VECTOR_ADDR)
    else $error("release values");
  a_lock_osc: assert property (watchdog_lock [*2] |-> !power_off[6])
    else $error("lock ignored");
  a_stop_first: assert property ($rose(power_off[1]) |-> !fro_clock_enable && !$past(fro_clock_enable))
    else $error("core off before stop");
  a_wake_sleep: assert property ($rose(wake_request) |-> $past(deep_sleep))
    else $error("stray wake");
  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_irq: cover property ($rose(brownout_irq));
  c_wake: cover property ($rose(wake_request));
  c_core_off: cover property ($rose(power_off[1]));
  c_chip_reset: cover property ($fell(chip_reset_n));
endmodule : power_reset_bod_control_properties

bind power_reset_bod_control power_reset_bod_control_properties #(.PART_ID(PART_ID)) props_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata), .ext_reset_n(ext_reset_n),
  .watchdog_reset(watchdog_reset), .power_on_detect(power_on_detect), .software_reset_req(software_reset_req),
  .supply_below(supply_below), .fro_running(fro_running), .watchdog_lock(watchdog_lock),
  .deep_sleep(deep_sleep), .chip_reset_n(chip_reset_n), .fro_clock_enable(fro_clock_enable),
  .power_off(power_off), .brownout_irq(brownout_irq), .wake_request(wake_request),
  .boot_vector_addr(boot_vector_addr)
);

/* File: sim/testbench.sv */
// Self-checking bench for the power, reset and brown-out slice
`timescale 1ns/1ps
module testbench;
  import sysctl_pkg::*;
  logic        ref_clk, reset_n, ext_reset_n, watchdog_reset, power_on_detect, software_reset_req;
  logic        fro_running, fro_clock_stopped, watchdog_lock, ic_en, deep_sleep;
  logic        chip_reset_n, fro_clock_enable, brownout_irq, wake_request;
  logic [2:0]  supply_below;
  logic [15:0] power_off;
  logic [31:0] rdata, boot_vector_addr, v, w;
  bus_req_t    bus_req;
  integer      seed = 6;
  int          err_total = 0;
  int          comparisons = 0;
  localparam logic [31:0] GATE = RUN_POWER_GATING_ADDR;

  power_reset_bod_control power_reset_bod_control_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata), .ext_reset_n(ext_reset_n),
    .watchdog_reset(watchdog_reset), .power_on_detect(power_on_detect), .software_reset_req(software_reset_req),
    .supply_below(supply_below), .fro_running(fro_running), .fro_clock_stopped(fro_clock_stopped),
    .watchdog_lock(watchdog_lock), .interrupt_controller_bod_enable(ic_en), .deep_sleep(deep_sleep),
    .chip_reset_n(chip_reset_n), .fro_clock_enable(fro_clock_enable), .power_off(power_off),
    .brownout_irq(brownout_irq), .wake_request(wake_request), .boot_vector_addr(boot_vector_addr));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task test_done;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : bus_wr

  // Data stand one cycle after the strobe
  task bus_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  task wait_until(input int sel, input logic lvl, input string name);
    logic s;
    s = ~lvl;
    for (int i = 0; i < 40 && s !== lvl; i++) begin
      @(posedge ref_clk);
      #1;
      case (sel)
        0: s = chip_reset_n;
        1: s = brownout_irq;
        2: s = wake_request;
        3: s = power_off[1];
        default: s = fro_clock_enable;
      endcase
    end
    check(name, {31'h0, s}, {31'h0, lvl});
  endtask : wait_until

  task set_src(input int k, input logic on);
    @(posedge ref_clk);
    case (k)
      0: software_reset_req <= on;
      1: watchdog_reset <= on;
      2: ext_reset_n <= ~on;
      default: power_on_detect <= on;
    endcase
  endtask : set_src

  function automatic logic [31:0] gate_exp(input logic [31:0] d);
    return {16'h0, d[15:0] & RUN_POWER_GATING_WMASK} | 32'h0000_0020;
  endfunction : gate_exp

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n, watchdog_reset, power_on_detect, software_reset_req, fro_clock_stopped} = '0;
    {watchdog_lock, ic_en, deep_sleep, supply_below} = '0;
    {ext_reset_n, fro_running} = 2'b11;
    bus_req = '0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 check("reset power", {16'h0, power_off}, 32'h0000_a070);
    check("reset clock en", {31'h0, fro_clock_enable}, 32'h1);
    wait_until(0, 1'b1, "boot release");
    check("boot vector", boot_vector_addr, BOOT_VECTOR_ADDR);
    bus_rd(GATE, v);
    check("gating reset", v, 32'h0000_a070);
    bus_wr(PART_IDENTIFICATION_ADDR, 32'hffff_ffff);
    bus_rd(PART_IDENTIFICATION_ADDR, v);
    check("part id", v, PART_ID_DEFAULT);
    bus_rd(32'h4004_8300, v);
    check("unmapped", v, 32'h0);
    for (int i = 0; i < 24; i++) begin
      w = $random(seed) & {16'h0, RUN_POWER_GATING_WMASK} & 32'hffff_fffd;
      if (i < 2) w = i ? 32'h0 : 32'h0000_a05d;
      bus_wr(GATE, w);
      bus_rd(GATE, v);
      check("readback", v, gate_exp(w));
      check("power lines", {16'h0, power_off}, gate_exp(w));
    end
    bus_wr(GATE, 32'h0000_0040);
    @(posedge ref_clk);
    watchdog_lock <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check("locked output", {16'h0, power_off}, 32'h0000_0020);
    bus_wr(GATE, 32'h0);
    bus_wr(GATE, 32'h0000_0040);
    bus_rd(GATE, v);
    check("locked write", v, 32'h0000_0020);
    watchdog_lock <= 1'b0;
    bus_wr(GATE, 32'h0000_0002);
    repeat (3) @(posedge ref_clk);
    #1 check("stop first", {fro_clock_enable, power_off[1]}, 32'h0);
    @(posedge ref_clk);
    {fro_clock_stopped, fro_running} <= 2'b10;
    wait_until(3, 1'b1, "core off");
    bus_wr(GATE, 32'h0);
    wait_until(3, 1'b0, "core on");
    @(posedge ref_clk);
    {fro_clock_stopped, fro_running} <= 2'b01;
    wait_until(4, 1'b1, "clock back");
    for (int k = 0; k < 4; k++) begin
      bus_wr(GATE, 32'h0000_0001);
      set_src(k, 1'b1);
      repeat (6) @(posedge ref_clk);
      bus_wr(GATE, 32'h0);
      #1 check("chip reset", {31'h0, chip_reset_n}, 32'h0);
      set_src(k, 1'b0);
      if (k == 2) begin
        fro_running <= 1'b0;
        repeat (12) @(posedge ref_clk);
        #1 check("held for osc", {31'h0, chip_reset_n}, 32'h0);
        @(posedge ref_clk);
        fro_running <= 1'b1;
      end
      wait_until(0, 1'b1, "release");
      bus_rd(GATE, v);
      check("gating after reset", v, 32'h0000_a070);
    end
    for (int s = 0; s < 4; s++) begin
      bus_wr(BROWNOUT_CTRL_ADDR, s);
      @(posedge ref_clk);
      supply_below <= (s == 3) ? 3'b111 : 3'b111 ^ (3'b001 << s);
      repeat (8) @(posedge ref_clk);
      #1 check("other level", {31'h0, brownout_irq}, 32'h0);
      if (s < 3) begin
        @(posedge ref_clk);
        supply_below <= 3'b001 << s;
        wait_until(1, 1'b1, "bod irq");
        bus_rd(RESET_STATUS_ADDR, v);
        check("status", v & 32'h1, 32'h1);
      end
      @(posedge ref_clk);
      supply_below <= 3'h0;
      wait_until(1, 1'b0, "bod clear");
    end
    bus_wr(BROWNOUT_CTRL_ADDR, 32'h0000_0100);
    {deep_sleep, supply_below} <= 4'b1001;
    wait_until(1, 1'b1, "sleep irq");
    repeat (4) @(posedge ref_clk);
    #1 check("masked wake", {31'h0, wake_request}, 32'h0);
    @(posedge ref_clk);
    ic_en <= 1'b1;
    wait_until(2, 1'b1, "irq wake");
    @(posedge ref_clk);
    {ic_en, supply_below} <= 4'h0;
    wait_until(1, 1'b0, "irq gone");
    bus_wr(BROWNOUT_CTRL_ADDR, 32'h0000_0010);
    supply_below <= 3'b001;
    wait_until(2, 1'b1, "reset wake");
    wait_until(0, 1'b0, "bod reset");
    check("reset irq", {31'h0, brownout_irq}, 32'h0);
    @(posedge ref_clk);
    {deep_sleep, supply_below} <= 4'h0;
    bus_wr(BROWNOUT_CTRL_ADDR, 32'h0);
    wait_until(0, 1'b1, "bod release");
    test_done();
  end

  // Sequence takes a few hundred cycles
  initial begin
    #(25 * 20000);
    err_total++;
    test_done();
  end
endmodule : testbench

/* File: src/pin_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Per-bit chain
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      // Only stage2 reads stage1, so metastability stays contained
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          stage1      <= INIT[i];
          stage2      <= INIT[i];
          stage3      <= INIT[i];
          sync_out[i] <= INIT[i];
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            sync_out[i] <= stage3;
          end
        end
      end
    end
  endgenerate

endmodule : pin_sync

/* File: src/power_reset_bod_control.sv */
// Power gating, reset merging and brown-out routing
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - Run power register gates each analog block, oscillator, flash; one means off
// - Power register writes accepted outside chip reset, immediate except fast oscillator core off
// - Fast oscillator clock stops cleanly first, then its power is removed
// - Bit 0 gates fast oscillator output path, resets to powered
// - Bit 1 gates fast oscillator core, resets to powered
// - Bit 6 gates low-power oscillator, resets to powered down
// - Watchdog lock keeps low-power oscillator running, ignoring power-down writes
// - Bit 15 gates analog comparator, resets to powered down
// - Read-only 32-bit part identification register, writes ignored
// - Chip reset merges pin, watchdog, power-on, brown-out and software requests
// - Reset starts fast oscillator; held until pin released and oscillator running
// - After reset release, processor fetches from address zero
// - Registers except brown-out control and reset cause hold reset values by the time internal reset is removed
// - Brown-out detector selects one of three thresholds, flags supply below it
// - Brown-out event resets chip if enabled, otherwise raises interrupt line
// - Brown-out interrupt level readable in a status register for polling
// - Enabled brown-out interrupt wakes chip from deep-sleep and power-down
// - Enabled brown-out reset also wakes chip from deep-sleep and power-down
module power_reset_bod_control
  import sysctl_pkg::*;
#(
  parameter logic [31:0] PART_ID = PART_ID_DEFAULT
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire sysctl_pkg::bus_req_t        bus_req,
  output logic [31:0]                      rdata,
  input  wire logic                        ext_reset_n,
  input  wire logic                        watchdog_reset,
  input  wire logic                        power_on_detect,
  input  wire logic                        software_reset_req,
  input  wire logic [2:0]                  supply_below,
  input  wire logic                        fro_running,
  input  wire logic                        fro_clock_stopped,
  input  wire logic                        watchdog_lock,
  input  wire logic                        interrupt_controller_bod_enable,
  input  wire logic                        deep_sleep,
  output logic                             chip_reset_n,
  output logic                             fro_clock_enable,
  output logic [15:0]                      power_off,
  output logic                             brownout_irq,
  output logic                             wake_request,
  output logic [31:0]                      boot_vector_addr
);

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  localparam int          SYNC_W    = 7;
  localparam logic [6:0]  SYNC_INIT = 7'h00;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_q;
  logic              pin_reset_n_s;
  logic              power_on_s;
  logic [2:0]        supply_below_s;
  logic              fro_running_s;
  logic              fro_stopped_s;

  assign sync_in = {fro_clock_stopped, fro_running, supply_below, power_on_detect, ext_reset_n};

  pin_sync #(
    .WIDTH (SYNC_W),
    .INIT  (SYNC_INIT)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  assign pin_reset_n_s  = sync_q[0];
  assign power_on_s     = sync_q[1];
  assign supply_below_s = sync_q[4:2];
  assign fro_running_s  = sync_q[5];
  assign fro_stopped_s  = sync_q[6];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0]            run_power_gating;
  logic [31:0]            brownout_ctrl;
  logic [CAUSE_COUNT-1:0] reset_cause;
  seq_state_t             seq_state;
  seq_state_t             next_seq_state;
  osc_state_t             osc_state;
  osc_state_t             next_osc_state;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire hit_gating = bus_req.addr == RUN_POWER_GATING_ADDR;
  wire hit_ident  = bus_req.addr == PART_IDENTIFICATION_ADDR;
  wire hit_bod    = bus_req.addr == BROWNOUT_CTRL_ADDR;
  wire hit_status = bus_req.addr == RESET_STATUS_ADDR;

  wire wr_gating  = bus_req.wr && hit_gating;
  wire wr_bod     = bus_req.wr && hit_bod;
  wire wr_status  = bus_req.wr && hit_status;

  // ----------------------------------------------------------------
  // Brown-out detection
  // ----------------------------------------------------------------
  wire [1:0] thresh_sel   = brownout_ctrl[THRESH_LSB +: 2];
  wire       bod_rst_en   = brownout_ctrl[RESET_ENABLE_BIT];
  wire       wake_start_en = brownout_ctrl[WAKE_START_ENABLE_BIT];
  // Detector output ignored while its own supply is gated off
  wire       bod_powered  = !run_power_gating[BROWNOUT_POWER_OFF_BIT];
  // Unused selector code disables detection rather than aliasing a level
  wire       bod_event    = bod_powered && (32'(thresh_sel) < THRESH_COUNT) && supply_below_s[thresh_sel];
  wire       bod_reset    = bod_event && bod_rst_en;
  wire       next_bod_irq = bod_event && !bod_rst_en;

  // ----------------------------------------------------------------
  // Reset merging
  // ----------------------------------------------------------------
  reset_src_t src;
  assign src.pin      = !pin_reset_n_s;
  assign src.watchdog = watchdog_reset;
  assign src.power_on = power_on_s;
  assign src.brownout = bod_reset;
  assign src.software = software_reset_req;

  wire any_src   = |src;
  wire in_reset  = seq_state != SEQ_RUN;

  // Sequencer: hold while any source stands, then wait for the oscillator
  always_comb begin
    next_seq_state = seq_state;
    case (seq_state)
      SEQ_RUN: begin
        if (any_src) begin
          next_seq_state = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (!any_src) begin
          next_seq_state = SEQ_OSC;
        end
      end
      SEQ_OSC: begin
        if (any_src) begin
          next_seq_state = SEQ_HOLD;
        end else if (fro_running_s) begin
          next_seq_state = SEQ_RUN;
        end
      end
      default: begin
        next_seq_state = SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq_state    <= SEQ_HOLD;
      chip_reset_n <= 1'b0;
    end else begin
      seq_state    <= next_seq_state;
      chip_reset_n <= next_seq_state == SEQ_RUN;
    end
  end

  // Constant vector, kept as a flop so the core sees a clean level
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      boot_vector_addr <= BOOT_VECTOR_ADDR;
    end else begin
      boot_vector_addr <= BOOT_VECTOR_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Run power gating register
  // ----------------------------------------------------------------
  // Reserved bits keep their reset value whatever software writes
  wire [15:0] masked_wdata = (run_power_gating & ~RUN_POWER_GATING_WMASK)
                           | (bus_req.wdata[15:0] & RUN_POWER_GATING_WMASK);
  wire        lpo_keep     = watchdog_lock && bus_req.wdata[LOW_POWER_OSC_OFF_BIT];
  wire [15:0] next_gating  = lpo_keep
                           ? {masked_wdata[15:7], run_power_gating[6], masked_wdata[5:0]}
                           : masked_wdata;

  // Chip reset restores the table so release finds defined values
  always_ff @(posedge ref_clk) begin
    if (!reset_n || in_reset) begin
      run_power_gating <= RUN_POWER_GATING_RESET;
    end else if (wr_gating) begin
      run_power_gating <= next_gating;
    end
  end

  // ----------------------------------------------------------------
  // Fast oscillator core shutdown
  // ----------------------------------------------------------------
  wire want_osc_off = run_power_gating[FAST_OSC_CORE_OFF_BIT] && !in_reset;

  always_comb begin
    next_osc_state = osc_state;
    case (osc_state)
      OSC_ON: begin
        if (want_osc_off) begin
          next_osc_state = OSC_STOP;
        end
      end
      OSC_STOP: begin
        if (!want_osc_off) begin
          next_osc_state = OSC_ON;
        end else if (fro_stopped_s) begin
          next_osc_state = OSC_OFF;
        end
      end
      OSC_OFF: begin
        if (!want_osc_off) begin
          next_osc_state = OSC_START;
        end
      end
      OSC_START: begin
        // Clock stays gated until the core reports stable running
        if (want_osc_off) begin
          next_osc_state = OSC_OFF;
        end else if (fro_running_s) begin
          next_osc_state = OSC_ON;
        end
      end
      default: begin
        next_osc_state = OSC_ON;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      osc_state        <= OSC_ON;
      fro_clock_enable <= 1'b1;
    end else begin
      osc_state        <= next_osc_state;
      fro_clock_enable <= next_osc_state == OSC_ON;
    end
  end

  // ----------------------------------------------------------------
  // Power-off outputs
  // ----------------------------------------------------------------
  logic [15:0] next_power_off;
  always_comb begin
    next_power_off = run_power_gating;
    next_power_off[FAST_OSC_OUTPUT_OFF_BIT] = run_power_gating[FAST_OSC_OUTPUT_OFF_BIT]
                                              && !in_reset;
    next_power_off[FAST_OSC_CORE_OFF_BIT]   = next_osc_state == OSC_OFF;
    next_power_off[LOW_POWER_OSC_OFF_BIT]   = run_power_gating[LOW_POWER_OSC_OFF_BIT]
                                              && !watchdog_lock;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      power_off <= RUN_POWER_GATING_RESET;
    end else begin
      power_off <= next_power_off;
    end
  end

  // ----------------------------------------------------------------
  // Brown-out control register
  // ----------------------------------------------------------------
  // Survives chip reset so an enabled brown-out reset stays armed
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      brownout_ctrl <= BROWNOUT_CTRL_RESET;
    end else if (wr_bod) begin
      brownout_ctrl <= bus_req.wdata & 32'h0000_0113;
    end
  end

  // ----------------------------------------------------------------
  // Reset cause, sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  wire [CAUSE_COUNT-1:0] cause_set = src;
  wire [CAUSE_COUNT-1:0] cause_clr = wr_status ? bus_req.wdata[CAUSE_LSB +: CAUSE_COUNT]
                                               : '0;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reset_cause <= '0;
    end else begin
      reset_cause <= (reset_cause & ~cause_clr) | cause_set;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line and wake-up
  // ----------------------------------------------------------------
  wire next_wake = deep_sleep
                 && ((next_bod_irq && wake_start_en && interrupt_controller_bod_enable)
                     || bod_reset);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      brownout_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      brownout_irq <= next_bod_irq;
      wake_request <= next_wake;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] status_word = {{(32-CAUSE_LSB-CAUSE_COUNT){1'b0}}, reset_cause,
                             3'h0, brownout_irq};
  wire [31:0] gating_word = {16'h0000, run_power_gating};
  wire [31:0] read_mux    = hit_gating ? gating_word
                          : hit_ident  ? PART_ID
                          : hit_bod    ? brownout_ctrl
                          : hit_status ? status_word
                          : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= bus_req.rd ? read_mux : 32'h0000_0000;
    end
  end

endmodule : power_reset_bod_control

/* File: src/sysctl_pkg.sv */
// Constants and carrier types for the power and reset slice
package sysctl_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] RUN_POWER_GATING_ADDR    = 32'h4004_8238;
  localparam logic [31:0] PART_IDENTIFICATION_ADDR = 32'h4004_83f8;
  localparam logic [31:0] BROWNOUT_CTRL_ADDR       = 32'h4004_8150;
  localparam logic [31:0] RESET_STATUS_ADDR        = 32'h4004_8154;

  // ----------------------------------------------------------------
  // Run power gating fields
  // ----------------------------------------------------------------
  localparam int          GATE_WIDTH               = 16;
  localparam int          FAST_OSC_OUTPUT_OFF_BIT  = 0;
  localparam int          FAST_OSC_CORE_OFF_BIT    = 1;
  localparam int          FLASH_POWER_OFF_BIT      = 2;
  localparam int          BROWNOUT_POWER_OFF_BIT   = 3;
  localparam int          CONVERTER_POWER_OFF_BIT  = 4;
  localparam int          LOW_POWER_OSC_OFF_BIT    = 6;
  localparam int          DAC_POWER_OFF_BIT        = 13;
  localparam int          COMPARATOR_POWER_OFF_BIT = 15;
  localparam logic [15:0] RUN_POWER_GATING_RESET   = 16'ha070;
  localparam logic [15:0] RUN_POWER_GATING_WMASK   = 16'ha05f;

  // ----------------------------------------------------------------
  // Brown-out control and status fields
  // ----------------------------------------------------------------
  localparam int          THRESH_LSB               = 0;
  localparam int          THRESH_COUNT             = 3;
  localparam int          RESET_ENABLE_BIT         = 4;
  localparam int          WAKE_START_ENABLE_BIT    = 8;
  localparam logic [31:0] BROWNOUT_CTRL_RESET      = 32'h0000_0000;
  localparam int          BROWNOUT_FLAG_BIT        = 0;
  localparam int          CAUSE_LSB                = 4;
  localparam int          CAUSE_COUNT              = 5;

  // ----------------------------------------------------------------
  // Identity and boot
  // ----------------------------------------------------------------
  // Arbitrary neutral identification value
  localparam logic [31:0] PART_ID_DEFAULT          = 32'h0000_1234;
  localparam logic [31:0] BOOT_VECTOR_ADDR         = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic software;
    logic brownout;
    logic power_on;
    logic watchdog;
    logic pin;
  } reset_src_t;

  typedef enum logic [1:0] {
    SEQ_RUN  = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_OSC  = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    OSC_ON    = 2'b00,
    OSC_STOP  = 2'b01,
    OSC_OFF   = 2'b11,
    OSC_START = 2'b10
  } osc_state_t;

endpackage : sysctl_pkg
